// ===== dss_sequencer.sv
// start/stop sequencer and motor thermal protection with apb settings
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
module dss_sequencer #(
   parameter int TICK_CYCLES = dss_pkg::TICK_CYCLES, // cycles per 0.1 s tick
   parameter int MODEL_W     = 24,                   // thermal model accumulator width
   parameter logic [23:0] MODEL_LIMIT = 24'h10_0000  // overload threshold of a model
) (
   input  wire logic        pclk,            // 40 MHz clock
   input  wire logic        presetn,         // async reset, active low
   input  wire logic        psel,            // apb select
   input  wire logic        penable,         // apb enable
   input  wire logic        pwrite,          // apb write
   input  wire logic [7:0]  paddr,           // apb byte address
   input  wire logic [31:0] pwdata,          // apb write data
   output logic      [31:0] prdata,          // apb read data
   output logic             pready,          // apb ready
   output logic             pslverr,         // apb error, unmapped address
   input  wire logic        start_req,       // start conditions met, level
   input  wire logic        stop_req,        // stop command, level
   input  wire logic [15:0] ref_freq,        // reference magnitude, 0.1 Hz
   input  wire logic        ref_reverse,     // reference direction counter-clockwise
   input  wire logic [15:0] out_freq,        // present output frequency, 0.1 Hz
   input  wire logic        brake_inv_in,    // digital input with inverse braking function
   input  wire logic [15:0] therm_ohm,       // thermistor resistance, ohm
   input  wire logic [15:0] motor_current,   // present current, same unit as rated
   input  wire logic [1:0]  active_setup,    // active setup 0..3 means 1..4
   output logic      [2:0]  out_mode,        // output mode, dss_out_mode_e
   output logic      [15:0] out_freq_cmd,    // fixed frequency command, 0.1 Hz
   output logic             out_reverse,     // commanded direction
   output logic      [7:0]  out_volt_pct,    // dc percent or initial voltage 0.1 V low
   output logic             overcurrent_risk,// frequency stepped without ramp
   output logic             thermal_warning, // overheating warning
   output logic             thermal_trip     // overheating trip
);
   // ****************************************
   // register map, byte addresses
   // ****************************************
   localparam logic [7:0] A_START_DELAY = 8'h00;
   localparam logic [7:0] A_START_MODE  = 8'h04;
   localparam logic [7:0] A_STOP_FUNC   = 8'h08;
   localparam logic [7:0] A_MIN_STOP_F  = 8'h0C;
   localparam logic [7:0] A_START_F     = 8'h10;
   localparam logic [7:0] A_INIT_VOLT   = 8'h14;
   localparam logic [7:0] A_HOLD_PCT    = 8'h18;
   localparam logic [7:0] A_BRAKE_PCT   = 8'h1C;
   localparam logic [7:0] A_BRAKE_TIME  = 8'h20;
   localparam logic [7:0] A_BRAKE_F     = 8'h24;
   localparam logic [7:0] A_THERM_SEL   = 8'h28;
   localparam logic [7:0] A_RATED       = 8'h2C;
   localparam logic [7:0] A_STATUS      = 8'h30;

   typedef enum logic [2:0] {
      ST_IDLE, ST_DELAY, ST_RUN, ST_BRAKE, ST_STOPPED
   } dss_state_e;

   // ****************************************
   // settings
   // ****************************************
   logic [6:0]  start_delay_reg;
   logic [2:0]  start_mode_reg;
   logic        stop_func_reg;
   logic [15:0] stop_function_min_freq_reg;
   logic [15:0] start_freq_reg;
   logic [11:0] init_volt_reg;
   logic [6:0]  hold_pct_reg;
   logic [6:0]  brake_pct_reg;
   logic [9:0]  brake_time_reg;
   logic [15:0] brake_engage_freq_reg;
   logic [3:0]  therm_sel_reg;
   logic [15:0] rated_current_reg;

   wire wr_en = psel & penable & pwrite;
   wire rd_en = psel & penable & ~pwrite;
   wire addr_ok = (paddr[1:0] == 2'b00) && (paddr <= A_STATUS);

   function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [15:0] lo,
                                           input logic [15:0] hi);
      if (v > {16'h0000, hi})
         clamp16 = hi;
      else if (v < {16'h0000, lo})
         clamp16 = lo;
      else
         clamp16 = v[15:0];
   endfunction : clamp16

   wire [15:0] wr_delay = clamp16(pwdata, 16'h0000, {9'h000, dss_pkg::START_DELAY_MAX});
   wire [15:0] wr_btime = clamp16(pwdata, 16'h0000, {6'h00, dss_pkg::BRAKE_TIME_MAX});
   wire [15:0] wr_minf  = clamp16(pwdata, dss_pkg::MIN_STOP_F_MIN, dss_pkg::MIN_STOP_F_MAX);
   wire [15:0] wr_stf   = clamp16(pwdata, 16'h0000, dss_pkg::START_F_MAX);
   wire [15:0] wr_hpct  = clamp16(pwdata, 16'h0000, {9'h000, dss_pkg::PCT_MAX});
   wire [15:0] wr_therm = clamp16(pwdata, 16'h0000, {12'h000, dss_pkg::THERM_SEL_MAX});
   wire        wr_mode_ok = pwdata[31:0] <= 32'h0000_0004;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_delay_reg            <= dss_pkg::START_DELAY_RST;       // RULE1
         start_mode_reg             <= dss_pkg::START_MODE_RST;        // RULE3
         stop_func_reg              <= 1'b0;                           // RULE9
         stop_function_min_freq_reg <= dss_pkg::MIN_STOP_F_MIN;        // RULE10
         start_freq_reg             <= 16'h0000;                       // RULE23
         init_volt_reg              <= 12'h000;
         hold_pct_reg               <= 7'd0;
         brake_pct_reg              <= 7'd0;                           // RULE13
         brake_time_reg             <= dss_pkg::BRAKE_TIME_RST;        // RULE16
         brake_engage_freq_reg      <= 16'h0000;                       // RULE17
         therm_sel_reg              <= 4'd0;                           // RULE18
         rated_current_reg          <= 16'h0064;
      end else if (wr_en) begin
         case (paddr)
            A_START_DELAY: start_delay_reg <= wr_delay[6:0];           // RULE1
            A_START_MODE:  if (wr_mode_ok) start_mode_reg <= pwdata[2:0]; // RULE3
            A_STOP_FUNC:   stop_func_reg <= pwdata[0];                  // RULE9
            A_MIN_STOP_F:  stop_function_min_freq_reg <= wr_minf;       // RULE10
            A_START_F:     start_freq_reg <= wr_stf;                    // RULE23
            A_INIT_VOLT:   init_volt_reg <= pwdata[11:0];
            A_HOLD_PCT:    hold_pct_reg <= wr_hpct[6:0];
            A_BRAKE_PCT:   brake_pct_reg <= wr_hpct[6:0];               // RULE13
            A_BRAKE_TIME:  brake_time_reg <= wr_btime[9:0];             // RULE16
            A_BRAKE_F:     brake_engage_freq_reg <= pwdata[15:0];       // RULE17
            A_THERM_SEL:   therm_sel_reg <= wr_therm[3:0];              // RULE18
            A_RATED:       rated_current_reg <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // ****************************************
   // 0.1 s tick and event edges
   // ****************************************
   localparam int TW = $clog2(TICK_CYCLES);
   logic [TW-1:0] tick_cnt_reg;
   logic          tick;
   logic          brake_inv_d_reg;
   logic          start_d_reg;
   logic          stop_d_reg;
   wire start_evt  = start_req & ~start_d_reg;
   wire stop_evt   = stop_req & ~stop_d_reg;
   wire inv_fall   = brake_inv_d_reg & ~brake_inv_in;                  // RULE14
   wire restart    = start_evt | stop_evt | inv_fall;
   assign tick = (tick_cnt_reg == TW'(TICK_CYCLES - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_reg    <= '0;
         brake_inv_d_reg <= 1'b1;
         start_d_reg     <= 1'b0;
         stop_d_reg      <= 1'b0;
      end else begin
         tick_cnt_reg    <= (tick || restart) ? '0 : tick_cnt_reg + 1'b1; // RULE24
         brake_inv_d_reg <= brake_inv_in;
         start_d_reg     <= start_req;
         stop_d_reg      <= stop_req;
      end
   end

   // ****************************************
   // sequencer
   // ****************************************
   dss_state_e  state_reg;
   dss_state_e  state_next;
   logic [9:0]  timer_reg;
   logic [9:0]  timer_next;
   wire skip_delay  = stop_function_min_freq_reg > start_freq_reg;      // RULE11
   wire brake_armed = brake_engage_freq_reg != 16'h0000;                // RULE17
   wire below_brake = brake_armed && (out_freq < brake_engage_freq_reg);// RULE15
   wire below_min   = out_freq < stop_function_min_freq_reg;            // RULE9
   wire timer_zero  = timer_reg == 10'd0;

   always_comb begin
      state_next = state_reg;
      timer_next = (tick && !timer_zero) ? timer_reg - 10'd1 : timer_reg; // RULE24
      if (inv_fall) begin
         state_next = ST_BRAKE;                                          // RULE14
         timer_next = brake_time_reg;                                    // RULE16
      end else begin
         case (state_reg)
            ST_IDLE, ST_STOPPED: begin
               if (start_evt || (start_req && !stop_req)) begin
                  if (skip_delay || start_delay_reg == 7'd0) begin
                     state_next = ST_RUN;                                // RULE11
                  end else begin
                     state_next = ST_DELAY;                              // RULE1
                     timer_next = {3'b000, start_delay_reg};
                  end
               end
            end
            ST_DELAY: begin
               if (stop_req)
                  state_next = ST_STOPPED;
               else if (timer_zero)
                  state_next = ST_RUN;                                   // RULE2
            end
            ST_RUN: begin
               if (stop_req && below_brake) begin
                  state_next = ST_BRAKE;                                 // RULE15
                  timer_next = brake_time_reg;                           // RULE16
               end else if (stop_req && (below_min || out_freq == 16'h0000))
                  state_next = ST_STOPPED;                               // RULE9
            end
            ST_BRAKE: begin
               if (timer_zero)
                  state_next = ST_STOPPED;                               // RULE16
            end
            default: state_next = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         timer_reg <= 10'd0;
      end else begin
         state_reg <= state_next;
         timer_reg <= timer_next;
      end
   end

   // ****************************************
   // output selection
   // ****************************************
   logic [2:0]  mode_w;
   logic [15:0] freq_w;
   logic [7:0]  volt_w;
   logic        rev_w;
   logic        ocr_w;
   wire  hold_stop = stop_func_reg;

   always_comb begin
      mode_w = dss_pkg::OM_OFF;
      freq_w = 16'h0000;
      volt_w = 8'h00;
      rev_w  = ref_reverse;
      ocr_w  = 1'b0;
      case (state_reg)
         ST_DELAY: begin
            case (start_mode_reg)
               dss_pkg::SM_DC_HOLD: begin
                  mode_w = dss_pkg::OM_DC_HOLD;                          // RULE4
                  volt_w = {1'b0, hold_pct_reg};
               end
               dss_pkg::SM_DC_BRAKE: begin
                  mode_w = dss_pkg::OM_DC_BRAKE;                         // RULE5
                  volt_w = {1'b0, brake_pct_reg};
               end
               dss_pkg::SM_CLOCKWISE: begin
                  mode_w = dss_pkg::OM_FIXED;                            // RULE7
                  freq_w = start_freq_reg;
                  volt_w = init_volt_reg[7:0];
                  rev_w  = 1'b0;
               end
               dss_pkg::SM_REF_DIR: begin
                  mode_w = dss_pkg::OM_FIXED;                            // RULE8
                  freq_w = (ref_freq == 16'h0000) ? 16'h0000 : start_freq_reg;
                  volt_w = init_volt_reg[7:0];
               end
               default: mode_w = dss_pkg::OM_OFF;                        // RULE6
            endcase
         end
         ST_RUN: begin
            if (hold_stop && below_min && !stop_req) begin
               mode_w = dss_pkg::OM_FIXED;                               // RULE12
               freq_w = stop_function_min_freq_reg;
               ocr_w  = 1'b1;
            end else
               mode_w = dss_pkg::OM_RAMP;                                // RULE2
         end
         ST_BRAKE: begin
            mode_w = dss_pkg::OM_DC_BRAKE;                               // RULE13
            volt_w = {1'b0, brake_pct_reg};
         end
         ST_STOPPED: begin
            if (hold_stop) begin
               mode_w = dss_pkg::OM_DC_HOLD;                             // RULE9
               volt_w = {1'b0, hold_pct_reg};
            end
         end
         default: mode_w = dss_pkg::OM_OFF;
      endcase
   end

   // ****************************************
   // thermal protection
   // ****************************************
   logic [MODEL_W-1:0] model_reg [4];
   logic [3:0]         model_over;
   wire therm_mode   = (therm_sel_reg == 4'd1) || (therm_sel_reg == 4'd2);
   wire model_mode   = therm_sel_reg >= 4'd3;
   wire [1:0] model_idx = 2'((therm_sel_reg - 4'd3) >> 1);
   wire is_trip      = therm_mode ? (therm_sel_reg == 4'd2) : ~therm_sel_reg[0];
   // derate allowed current below half rated frequency: cooling fan slows down
   wire [15:0] allowed = (out_freq < 16'h00FA) ? (rated_current_reg - (rated_current_reg >> 2))
                                              : rated_current_reg;   // RULE20
   wire hot_thermistor = therm_ohm > dss_pkg::THERM_CUTOUT_OHM;         // RULE19

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_model
         // only the model of the active setup integrates, the rest keep their load
         wire active = model_mode && (model_idx == 2'(g)) && (active_setup == 2'(g)); // RULE21
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn)
               model_reg[g] <= '0;
            else if (active && tick) begin
               if (motor_current > allowed)
                  model_reg[g] <= model_reg[g] + MODEL_W'(motor_current - allowed); // RULE20
               else if (model_reg[g] > MODEL_W'(allowed - motor_current))
                  model_reg[g] <= model_reg[g] - MODEL_W'(allowed - motor_current);
               else
                  model_reg[g] <= '0;
            end
         end
         assign model_over[g] = active && (model_reg[g] >= MODEL_LIMIT);
      end
   endgenerate

   wire overheat = (therm_mode && hot_thermistor) || (|model_over);     // RULE19

   // ****************************************
   // registered outputs and apb read
   // ****************************************
   logic [31:0] rd_w;
   always_comb begin
      case (paddr)
         A_START_DELAY: rd_w = {25'h0, start_delay_reg};
         A_START_MODE:  rd_w = {29'h0, start_mode_reg};
         A_STOP_FUNC:   rd_w = {31'h0, stop_func_reg};
         A_MIN_STOP_F:  rd_w = {16'h0, stop_function_min_freq_reg};
         A_START_F:     rd_w = {16'h0, start_freq_reg};
         A_INIT_VOLT:   rd_w = {20'h0, init_volt_reg};
         A_HOLD_PCT:    rd_w = {25'h0, hold_pct_reg};
         A_BRAKE_PCT:   rd_w = {25'h0, brake_pct_reg};
         A_BRAKE_TIME:  rd_w = {22'h0, brake_time_reg};
         A_BRAKE_F:     rd_w = {16'h0, brake_engage_freq_reg};
         A_THERM_SEL:   rd_w = {28'h0, therm_sel_reg};
         A_RATED:       rd_w = {16'h0, rated_current_reg};
         A_STATUS:      rd_w = {16'h0, timer_reg[7:0], 1'b0, state_reg, thermal_trip,
                                thermal_warning, overcurrent_risk, skip_delay};
         default:       rd_w = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_mode         <= dss_pkg::OM_OFF;
         out_freq_cmd     <= 16'h0000;
         out_reverse      <= 1'b0;
         out_volt_pct     <= 8'h00;
         overcurrent_risk <= 1'b0;
         thermal_warning  <= 1'b0;
         thermal_trip     <= 1'b0;
         prdata           <= 32'h0000_0000;
         pready           <= 1'b0;
         pslverr          <= 1'b0;
      end else begin
         out_mode         <= mode_w;
         out_freq_cmd     <= freq_w;
         out_reverse      <= rev_w;
         out_volt_pct     <= volt_w;
         overcurrent_risk <= ocr_w;                                      // RULE12
         thermal_warning  <= overheat && !is_trip;                       // RULE22
         // a trip latches until software clears the selector to none
         thermal_trip     <= (thermal_trip && therm_sel_reg != 4'd0) || (overheat && is_trip); // RULE22
         pready           <= psel & ~penable;
         pslverr          <= psel & ~penable & ~addr_ok;
         if (rd_en)
            prdata <= rd_w;
         else if (psel && !penable)
            prdata <= addr_ok ? rd_w : 32'h0000_0000;
      end
   end
endmodule : dss_sequencer

// ===== dss_pkg.sv
// package of constants for the drive start/stop sequencer
//
// Functional notes
// (RULE1) start delay 0.0 to 10.0 s, default zero, holds off acceleration
// (RULE2) after the delay the output ramps toward the reference
// (RULE3) start mode codes: 0 hold, 1 brake, 2 coast, 3 clockwise, 4 reference dir
// (RULE4) mode 0 applies dc hold voltage during the delay
// (RULE5) mode 1 applies dc brake voltage during the delay
// (RULE6) mode 2 switches inverter off during the delay
// (RULE7) mode 3 outputs start frequency and initial voltage regardless of reference
// (RULE8) mode 4 follows reference direction; zero reference gives 0 Hz at initial voltage
// (RULE9) stop function 0 coast, 1 dc hold, below minimum frequency or at zero
// (RULE10) minimum stop frequency 0.1 to 10 Hz, default 0.1 Hz
// (RULE11) minimum stop frequency above start frequency skips the start delay
// (RULE12) dc hold stop with high minimum steps frequency without ramp, flags overcurrent risk
// (RULE13) dc brake voltage is 0 to 100 percent of maximum brake voltage
// (RULE14) inverse brake input falling from one to zero starts dc braking
// (RULE15) with stop active, braking starts below the brake engage frequency
// (RULE16) brake time 0 to 60 s, default 10 s
// (RULE17) brake engage frequency zero means off, disables stop-triggered braking
// (RULE18) thermal selector codes 0 to 10: none, thermistor, model warn/trip 1 to 4
// (RULE19) thermistor above 3 kilohm flags overheating as warning or trip
// (RULE20) thermal model integrates load versus rated current, derated at low speed
// (RULE21) model instance n accumulates only while setup n is active
// (RULE22) model overload gives warning output in warn modes, trip in trip modes
// (RULE23) start frequency 0.0 to 10.0 Hz, default 0.0 Hz
// (RULE24) timers tick every 0.1 s, restarted on each start or stop event
package dss_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_HZ          = 40_000_000;
   localparam int TICK_MS         = 100;
   localparam int TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
   // ****************************************
   // settings ranges, frequencies in 0.1 Hz, times in 0.1 s
   // ****************************************
   localparam logic [6:0]  START_DELAY_MAX   = 7'd100;
   localparam logic [6:0]  START_DELAY_RST   = 7'd0;
   localparam logic [9:0]  BRAKE_TIME_MAX    = 10'd600;
   localparam logic [9:0]  BRAKE_TIME_RST    = 10'd100;
   localparam logic [15:0] MIN_STOP_F_MIN    = 16'h0001;
   localparam logic [15:0] MIN_STOP_F_MAX    = 16'h0064;
   localparam logic [15:0] START_F_MAX       = 16'h0064;
   localparam logic [6:0]  PCT_MAX           = 7'd100;
   localparam logic [15:0] THERM_CUTOUT_OHM  = 16'h0BB8;
   localparam logic [3:0]  THERM_SEL_MAX     = 4'd10;
   localparam logic [2:0]  START_MODE_RST    = 3'd2;
   // ****************************************
   // enumerations
   // ****************************************
   typedef enum logic [2:0] {
      SM_DC_HOLD, SM_DC_BRAKE, SM_COAST, SM_CLOCKWISE, SM_REF_DIR
   } dss_start_mode_e;
   typedef enum logic [2:0] {
      OM_OFF, OM_RAMP, OM_FIXED, OM_DC_HOLD, OM_DC_BRAKE
   } dss_out_mode_e;
endpackage : dss_pkg

// ===== dss_sequencer_properties.sv
// port assertions of the start/stop sequencer
`timescale 1ns/1ps
module dss_seq_checker (
   input wire logic        pclk,         // clock
   input wire logic        presetn,      // reset, low
   input wire logic        psel,         // select
   input wire logic        penable,      // enable
   input wire logic        pwrite,       // write
   input wire logic [7:0]  paddr,        // address
   input wire logic        pready,       // ready
   input wire logic        pslverr,      // error
   input wire logic        brake_inv_in, // brake input
   input wire logic [2:0]  out_mode,     // mode
   input wire logic [15:0] out_freq_cmd, // fixed freq
   input wire logic [7:0]  out_volt_pct, // voltage
   input wire logic        thermal_trip  // trip
);
   // ********
   // checks
   // ********
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic sel_clr = psel && penable && pwrite && paddr == 8'h28;
   apb_answer_a: assert property (psel && !penable |=> pready)
      else $error("no pready after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready too long");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr alone");
   mode_legal_a: assert property (out_mode <= 3'h4)
      else $error("bad out_mode");
   fixed_freq_a: assert property (out_mode == 3'h2 |-> out_freq_cmd <= 16'h64)
      else $error("start freq range");
   dc_pct_a: assert property (out_mode inside {3'h3, 3'h4} |-> out_volt_pct <= 8'h64)
      else $error("dc percent range");
   brake_fall_a: assert property ($fell(brake_inv_in) && !thermal_trip |-> ##2 out_mode == 3'h4)
      else $error("no brake on falling input");
   trip_hold_a: assert property (thermal_trip && !sel_clr && !$past(sel_clr) |=> thermal_trip)
      else $error("trip dropped");
   cover property (out_mode == 3'h2);
   cover property (thermal_trip);
   cover property (pslverr);
endmodule : dss_seq_checker
bind dss_sequencer dss_seq_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .brake_inv_in(brake_inv_in), .out_mode(out_mode), .out_freq_cmd(out_freq_cmd),
   .out_volt_pct(out_volt_pct), .thermal_trip(thermal_trip));

// ===== dss_motor_model.sv
// behavioural motor and thermistor beside the sequencer
`timescale 1ns/1ps
module dss_motor_model (
   input  wire logic        pclk,     // clock
   input  wire logic        presetn,  // reset, low
   input  wire logic [2:0]  out_mode, // drive mode
   input  wire logic [15:0] ref_freq, // reference
   input  wire logic        stop_req, // stop
   input  wire logic        hot,      // overheated
   output logic      [15:0] out_freq, // shaft freq
   output logic      [15:0] therm_ohm // thermistor
);
   // ********
   // motor
   // ********
   // one step a cycle keeps stops short; a real ramp is far slower
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         out_freq <= 16'h0;
      else if (out_mode != 3'h1)
         out_freq <= 16'h0;
      else if (stop_req)
         out_freq <= (out_freq == 16'h0) ? out_freq : out_freq - 16'h1;
      else if (out_freq < ref_freq)
         out_freq <= out_freq + 16'h1;
   end
   assign therm_ohm = hot ? 16'h0FA0 : 16'h03E8;
endmodule : dss_motor_model

// ===== tb.sv
// self-checking bench for the start/stop sequencer
`timescale 1ns/1ps
module tb;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        start_req = 1'b0, stop_req = 1'b0, ref_reverse = 1'b1, brake_inv_in = 1'b1;
   logic        hot = 1'b0, pready, pslverr, out_reverse, overcurrent_risk;
   logic        thermal_warning, thermal_trip;
   logic [1:0]  active_setup = 2'h0;
   logic [2:0]  out_mode;
   logic [7:0]  paddr = 8'h0, out_volt_pct;
   logic [15:0] ref_freq = 16'h14, motor_current = 16'h0, lfsr = 16'h2B85, sf;
   logic [15:0] out_freq, therm_ohm, out_freq_cmd;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [32:0] exp_q[$];
   logic [31:0] rst_tab[12] = '{32'h0, 32'h2, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0,
                                32'h64, 32'h0, 32'h0, 32'h64};
   logic [2:0]  dly_mode[5] = '{3'h3, 3'h4, 3'h0, 3'h2, 3'h2};
   int          error_cnt = 0, n_tests = 0;
   dss_sequencer #(.TICK_CYCLES(10), .MODEL_LIMIT(24'h00_0100)) dut_u (.*);
   dss_motor_model motor_u (.*);
   // ********
   // tasks
   // ********
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr_next
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      int n = 0;
      exp_q.push_back(e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (!pready && n < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      if (!pready) begin
         error_cnt++;
         summarize();
      end
   endtask : apb
   task automatic wait_mode(input logic [2:0] m);
      int n = 0;
      while (out_mode !== m && n < 2000) begin
         @(posedge pclk);
         n++;
      end
      chk({30'h0, out_mode}, {30'h0, m}, "out_mode");
   endtask : wait_mode
   task automatic stop_idle(input logic [2:0] m);
      start_req <= 1'b0;
      stop_req <= 1'b1;
      wait_mode(m);
      stop_req <= 1'b0;
   endtask : stop_idle
   task automatic therm(input logic [31:0] sel, input logic h, input logic [1:0] e);
      apb(1'b1, 8'h28, sel, 33'h0);
      hot <= h;
      repeat (12) @(posedge pclk);
      chk({31'h0, thermal_warning, thermal_trip}, {31'h0, e}, "thermal");
   endtask : therm
   // responses leave the queue in issue order
   always @(posedge pclk)
      if (psel && penable && pready)
         chk({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front(), "apb");
   initial forever #12.5 pclk = ~pclk;
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rst_tab[i]) apb(1'b0, 8'(4 * i), 32'h0, {1'b0, rst_tab[i]});
      apb(1'b0, 8'h34, 32'h0, 33'h1_0000_0000);
      sf = 16'h22 + lfsr_next(lfsr) % 16'h42;
      foreach (rst_tab[i]) if (i > 0 && i < 9)
         apb(1'b1, 8'(4 * i), i == 4 ? {16'h0, sf} : 32'(8'h0B * i), 33'h0);
      apb(1'b1, 8'h00, 32'h3, 33'h0);
      apb(1'b1, 8'h04, 32'h5, 33'h0);
      apb(1'b0, 8'h04, 32'h0, {1'b0, 32'h2});
      $display("register test done");
      for (int m = 0; m < 5; m++) begin
         apb(1'b1, 8'h04, 32'(m), 33'h0);
         start_req <= 1'b1;
         motor_current <= lfsr_next(sf);
         repeat (5) @(posedge pclk);
         chk({30'h0, out_mode}, {30'h0, dly_mode[m]}, "delay mode");
         if (m < 2) chk({25'h0, out_volt_pct}, {25'h0, 8'h42 + 8'h0B * 8'(m)}, "dc");
         if (m > 2) chk({out_freq_cmd, out_reverse}, {sf, m == 4}, "boost");
         wait_mode(3'h1);
         if (m == 4) begin
            brake_inv_in <= 1'b0;
            repeat (3) @(posedge pclk);
            chk({30'h0, out_mode}, {30'h0, 3'h4}, "brake");
            brake_inv_in <= 1'b1;
         end
         stop_idle(3'h0);
      end
      $display("start mode test done");
      apb(1'b1, 8'h0C, 32'hC8, 33'h0);
      apb(1'b0, 8'h0C, 32'h0, {1'b0, 32'h64});
      apb(1'b1, 8'h08, 32'h1, 33'h0);
      apb(1'b1, 8'h24, 32'h5, 33'h0);
      start_req <= 1'b1;
      repeat (4) @(posedge pclk);
      chk({14'h0, out_mode, out_freq_cmd}, {14'h0, 3'h2, 16'h64}, "skip");
      repeat (4) @(posedge pclk);
      chk({32'h0, overcurrent_risk}, 33'h1, "step");
      stop_idle(3'h4);
      $display("stop test done");
      therm(32'h1, 1'b1, 2'h2);
      therm(32'h2, 1'b1, 2'h1);
      therm(32'h2, 1'b0, 2'h1);
      therm(32'h0, 1'b0, 2'h0);
      motor_current <= 16'hFFFF;
      therm(32'h6, 1'b0, 2'h0);
      therm(32'h3, 1'b0, 2'h2);
      therm(32'h4, 1'b0, 2'h1);
      $display("thermal test done");
      summarize();
   end
endmodule : tb
